// File: scg_bus_if.sv
// Interface carrying per-unit access checks to the fault module
`timescale 1ns/1ps
interface scg_bus_if;
  logic [10:0] gate;
  logic [10:0] unit_req;
  logic fault;
  modport ctrl (output gate, output unit_req, input fault);
  modport chk (input gate, input unit_req, output fault);
endinterface

// File: scg_clock_gate.sv
// Top of the sleep-mode clock gating block
//
// Functional notes
// - A set gating bit clocks its unit during sleep.
// - A clear gating bit stops its unit clock during sleep.
// - Access to an unclocked unit ends with a bus fault.
// - Reset clears the whole sleep gating register to zero.
// - Run, sleep and deep-sleep sets are chosen by operating state.
// - Sleep set applies only with automatic gating selected.
// - Bit 24 gates analog comparator 0, read/write, resets zero.
// - Timers bits 19:16, I2C bit 12, serial 5:4, UARTs 2:0.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module scg_clock_gate
  import scg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // Power state from the core
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  // Unit access requests, one bit per gated unit
  input wire logic [UNITS-1:0] unit_access,
  // Unit clock enables and fault
  output logic [UNITS-1:0] unit_clk_en,
  output logic bus_fault
);
  scg_bus_if bus ();

  logic [31:0] run_gate;
  logic [31:0] sleep_gate;
  logic [31:0] deep_gate;
  logic [31:0] run_cfg;
  logic [31:0] next_run_gate;
  logic [31:0] next_sleep_gate;
  logic [31:0] next_deep_gate;
  logic [31:0] next_run_cfg;
  logic [31:0] next_rdata;
  logic [UNITS-1:0] next_unit_clk_en;
  scg_state_e state;
  scg_state_e next_state;

  // Gather the eleven gating bits of a register into a unit vector
  function automatic logic [UNITS-1:0] units_of(input logic [31:0] r);
    units_of = {r[POS_COMPARATOR_ZERO],
      r[POS_GP_TIMER_ZERO +: 4], r[POS_I2C_UNIT_ZERO],
      r[POS_SYNC_SERIAL_ZERO +: 2], r[POS_ASYNC_SERIAL_ZERO +: 3]};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Register writes
  always_comb begin
    next_run_gate = run_gate;
    next_sleep_gate = sleep_gate;
    next_deep_gate = deep_gate;
    next_run_cfg = run_cfg;
    if (wr) begin
      unique case (addr)
        OFS_RUN_CLOCK_GATE_1: next_run_gate = wdata & GATE_MASK;
        OFS_SLEEP_CLOCK_GATE_1: next_sleep_gate = wdata & GATE_MASK;
        OFS_DEEP_SLEEP_CLOCK_GATE_1: next_deep_gate = wdata & GATE_MASK;
        OFS_RUN_CLOCK_CONFIG: next_run_cfg = wdata & CONFIG_MASK;
        default: ;
      endcase
    end
  end

  // Register state, all clear at reset
  always_ff @(posedge clk) begin
    if (srst) begin
      run_gate <= GATE_RESET;
      sleep_gate <= GATE_RESET;
      deep_gate <= GATE_RESET;
      run_cfg <= CONFIG_RESET;
    end else begin
      run_gate <= next_run_gate;
      sleep_gate <= next_sleep_gate;
      deep_gate <= next_deep_gate;
      run_cfg <= next_run_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        OFS_RUN_CLOCK_GATE_1: next_rdata = run_gate;
        OFS_SLEEP_CLOCK_GATE_1: next_rdata = sleep_gate;
        OFS_DEEP_SLEEP_CLOCK_GATE_1: next_rdata = deep_gate;
        OFS_RUN_CLOCK_CONFIG: next_rdata = run_cfg;
        OFS_POWER_STATE: next_rdata = {30'h0000_0000, state};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Operating state and clock enable selection
  always_comb begin
    if (deep_sleep_req) begin
      next_state = SCG_DEEP;
    end else if (sleep_req) begin
      next_state = SCG_SLEEP;
    end else begin
      next_state = SCG_RUN;
    end
    unique case (state)
      SCG_RUN: next_unit_clk_en = units_of(run_gate);
      SCG_SLEEP: next_unit_clk_en = run_cfg[POS_AUTO_CLOCK_GATING]
        ? units_of(sleep_gate) : units_of(run_gate);
      SCG_DEEP: next_unit_clk_en = run_cfg[POS_AUTO_CLOCK_GATING]
        ? units_of(deep_gate) : units_of(run_gate);
      default: next_unit_clk_en = units_of(run_gate);
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SCG_RUN;
      unit_clk_en <= '0;
    end else begin
      state <= next_state;
      unit_clk_en <= next_unit_clk_en;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Fault check against the live enables
  assign bus.gate = unit_clk_en;
  assign bus.unit_req = unit_access;
  assign bus_fault = bus.fault;

  scg_fault u_fault (
    .clk(clk),
    .srst(srst),
    .bus(bus)
  );

  //////////////////////////////////////////////////////////////////////
  // Assertions
  a_sleep_enable: assert property (@(posedge clk) disable iff (srst)
    state == SCG_SLEEP && run_cfg[POS_AUTO_CLOCK_GATING] |=>
    unit_clk_en == units_of($past(sleep_gate)))
    else $error("sleep enables do not follow sleep register");
  a_sleep_stop: assert property (@(posedge clk) disable iff (srst)
    state == SCG_SLEEP && run_cfg[POS_AUTO_CLOCK_GATING] && !sleep_gate[0]
    |=> !unit_clk_en[0])
    else $error("unit clocked while gated off");
  a_reset_clear: assert property (@(posedge clk)
    srst |=> sleep_gate == 32'h0000_0000 && unit_clk_en == '0 && !bus_fault)
    else $error("reset did not clear gating");
  a_run_select: assert property (@(posedge clk) disable iff (srst)
    state == SCG_RUN |=> unit_clk_en == units_of($past(run_gate)))
    else $error("run enables wrong");
  a_deep_select: assert property (@(posedge clk) disable iff (srst)
    state == SCG_DEEP && run_cfg[POS_AUTO_CLOCK_GATING] |=>
    unit_clk_en == units_of($past(deep_gate)))
    else $error("deep sleep enables wrong");
  a_state_deep: assert property (@(posedge clk) disable iff (srst)
    deep_sleep_req |=> state == SCG_DEEP)
    else $error("deep sleep request not taken");
  a_state_sleep: assert property (@(posedge clk) disable iff (srst)
    sleep_req && !deep_sleep_req |=> state == SCG_SLEEP)
    else $error("sleep request not taken");
  a_no_auto: assert property (@(posedge clk) disable iff (srst)
    state != SCG_RUN && !run_cfg[POS_AUTO_CLOCK_GATING] |=>
    unit_clk_en == units_of($past(run_gate)))
    else $error("sleep set used without automatic gating");
  a_comp_bit: assert property (@(posedge clk) disable iff (srst)
    wr && addr == OFS_SLEEP_CLOCK_GATE_1 |=> sleep_gate[24] == $past(wdata[24]))
    else $error("comparator bit not written");
  a_sleep_comp: assert property (@(posedge clk) disable iff (srst)
    state == SCG_SLEEP && run_cfg[POS_AUTO_CLOCK_GATING] |=>
    unit_clk_en[UNITS-1] == $past(sleep_gate[POS_COMPARATOR_ZERO]))
    else $error("comparator clock does not follow its bit");
  a_uart_bits: assert property (@(posedge clk) disable iff (srst)
    wr && addr == OFS_SLEEP_CLOCK_GATE_1 |=> sleep_gate[2:0] == $past(wdata[2:0]))
    else $error("serial bits not written");
  a_unit_bits: assert property (@(posedge clk) disable iff (srst)
    wr && addr == OFS_SLEEP_CLOCK_GATE_1 |=> sleep_gate[19:16] == $past(wdata[19:16])
    && sleep_gate[12] == $past(wdata[12]) && sleep_gate[5:4] == $past(wdata[5:4]))
    else $error("timer, two-wire or sync serial bits not written");
  a_resv_zero: assert property (@(posedge clk) disable iff (srst)
    rd && addr == OFS_SLEEP_CLOCK_GATE_1 |=> (rdata & ~GATE_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  a_resv_write: assert property (@(posedge clk) disable iff (srst)
    wr && addr == OFS_SLEEP_CLOCK_GATE_1 |=> (sleep_gate & ~GATE_MASK) == 32'h0000_0000)
    else $error("reserved bits took a write");
  a_read_back: assert property (@(posedge clk) disable iff (srst)
    wr && addr == OFS_SLEEP_CLOCK_GATE_1 ##1 rd && addr == OFS_SLEEP_CLOCK_GATE_1
    |=> rdata == ($past(wdata, 2) & GATE_MASK))
    else $error("read back mismatch");

  // Main scenarios reached
  c_sleep_gated: cover property (@(posedge clk) disable iff (srst)
    state == SCG_SLEEP && run_cfg[POS_AUTO_CLOCK_GATING]);
  c_sleep_run_set: cover property (@(posedge clk) disable iff (srst)
    state == SCG_SLEEP && !run_cfg[POS_AUTO_CLOCK_GATING]);
  c_read_back: cover property (@(posedge clk) disable iff (srst)
    wr && addr == OFS_SLEEP_CLOCK_GATE_1 ##1 rd && addr == OFS_SLEEP_CLOCK_GATE_1);
  c_fault: cover property (@(posedge clk) disable iff (srst) bus_fault);
  c_deep: cover property (@(posedge clk) disable iff (srst) state == SCG_DEEP);
endmodule

// File: scg_fault.sv
// Bus fault decision for accesses to gated units
`timescale 1ns/1ps
module scg_fault
  import scg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Gate and request view
  scg_bus_if.chk bus
);
  logic fault;
  logic next_fault;

  // Fault when any requested unit has no clock
  always_comb begin
    next_fault = |(bus.unit_req & ~bus.gate);
  end

  // Fault register
  always_ff @(posedge clk) begin
    if (srst) begin
      fault <= 1'b0;
    end else begin
      fault <= next_fault;
    end
  end

  assign bus.fault = fault;

  a_fault_gated: assert property (@(posedge clk) disable iff (srst)
    |(bus.unit_req & ~bus.gate) |=> fault)
    else $error("access to gated unit gave no fault");
  a_fault_clear: assert property (@(posedge clk) disable iff (srst)
    !(|(bus.unit_req & ~bus.gate)) |=> !fault)
    else $error("fault raised with every requested unit clocked");
endmodule

// File: scg_pkg.sv
// Package for the sleep-mode clock gating block
package scg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int UNITS = 11;
  // Register byte offsets
  localparam logic [11:0] OFS_RUN_CLOCK_GATE_1 = 12'h104;
  localparam logic [11:0] OFS_SLEEP_CLOCK_GATE_1 = 12'h114;
  localparam logic [11:0] OFS_DEEP_SLEEP_CLOCK_GATE_1 = 12'h124;
  localparam logic [11:0] OFS_RUN_CLOCK_CONFIG = 12'h060;
  localparam logic [11:0] OFS_POWER_STATE = 12'h070;
  // Gating field positions
  localparam int POS_COMPARATOR_ZERO = 24;
  localparam int POS_GP_TIMER_ZERO = 16;
  localparam int POS_I2C_UNIT_ZERO = 12;
  localparam int POS_SYNC_SERIAL_ZERO = 4;
  localparam int POS_ASYNC_SERIAL_ZERO = 0;
  localparam int POS_AUTO_CLOCK_GATING = 27;
  // Writable bits of the gating registers
  localparam logic [31:0] GATE_MASK = 32'h010f_1037;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_MASK = 32'h0800_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  // Operating states
  typedef enum logic [1:0] {SCG_RUN, SCG_SLEEP, SCG_DEEP} scg_state_e;
endpackage

// File: sleep_mode_clock_gating_tb_top.sv
// Self-checking testbench for the sleep-mode clock gating block
`timescale 1ns/1ps
module sleep_mode_clock_gating_tb_top;
  import scg_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep_req = 1'b0;
  logic deep_sleep_req = 1'b0;
  logic bus_fault;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [10:0] unit_access = 11'h000;
  logic [10:0] unit_clk_en;
  logic [31:0] seed = 32'h0000_004d;
  logic [31:0] m_run = 32'h0;
  logic [31:0] m_slp = 32'h0;
  logic [31:0] m_deep = 32'h0;
  logic [31:0] m_cfg = 32'h0;
  logic [31:0] m_pwr = 32'h0;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  scg_clock_gate dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .unit_access(unit_access), .unit_clk_en(unit_clk_en), .bus_fault(bus_fault));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Model helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Register bits to enable order
  function automatic logic [10:0] pick(input logic [31:0] r);
    return {r[24], r[19:16], r[12], r[5:4], r[2:0]};
  endfunction
  function automatic logic [31:0] m_read(input logic [11:0] a);
    case (a)
      OFS_RUN_CLOCK_GATE_1: return m_run;
      OFS_SLEEP_CLOCK_GATE_1: return m_slp;
      OFS_DEEP_SLEEP_CLOCK_GATE_1: return m_deep;
      OFS_RUN_CLOCK_CONFIG: return m_cfg;
      OFS_POWER_STATE: return m_pwr;
      default: return 32'h0;
    endcase
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Clock enable vector compare
  task automatic cmp_en(input logic [10:0] got, input logic [10:0] exp);
    cmp({21'h0, got}, {21'h0, exp});
  endtask
  // Bus fault compare
  task automatic cmp_fault(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  // One-cycle write, model follows
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == OFS_RUN_CLOCK_GATE_1) m_run = d & GATE_MASK;
    if (a == OFS_SLEEP_CLOCK_GATE_1) m_slp = d & GATE_MASK;
    if (a == OFS_DEEP_SLEEP_CLOCK_GATE_1) m_deep = d & GATE_MASK;
    if (a == OFS_RUN_CLOCK_CONFIG) m_cfg = d & CONFIG_MASK;
  endtask
  // One-cycle read, data checked in the following cycle
  task automatic rd_chk(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, m_read(a));
  endtask
  // Sleep register write then read, strobes back to back
  task automatic wr_rd_slp(input logic [31:0] d);
    @(posedge clk);
    addr <= OFS_SLEEP_CLOCK_GATE_1;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    m_slp = d & GATE_MASK;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, m_slp);
  endtask

  task automatic give_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [11:0] regs [4];
    logic [10:0] en;
    int s;
    regs = '{OFS_RUN_CLOCK_GATE_1, OFS_SLEEP_CLOCK_GATE_1, OFS_DEEP_SLEEP_CLOCK_GATE_1,
      OFS_RUN_CLOCK_CONFIG};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(regs[i]);
    #1 cmp_en(unit_clk_en, 11'h000);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      wr_reg(regs[i % 4], xs());
      rd_chk(regs[i % 4]);
    end
    wr_reg(12'h200, xs());
    rd_chk(12'h200);
    for (int i = 0; i < 4; i++) wr_rd_slp(xs());
    rd_chk(OFS_SLEEP_CLOCK_GATE_1);
    wr_reg(OFS_SLEEP_CLOCK_GATE_1, m_slp | 32'h0000_1000);
    rd_chk(OFS_SLEEP_CLOCK_GATE_1);
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      wr_reg(OFS_RUN_CLOCK_CONFIG, k[0] ? 32'h0800_0000 : 32'h0);
      s = k >> 1;
      m_pwr = 32'(s);
      sleep_req <= (s != 0);
      deep_sleep_req <= (s == 2);
      en = !k[0] || s == 0 ? pick(m_run) : s == 1 ? pick(m_slp) : pick(m_deep);
      repeat (3) @(posedge clk);
      #1 cmp_en(unit_clk_en, en);
      for (int j = 0; j < 4; j++) begin
        @(posedge clk);
        unit_access <= 11'(xs());
        @(posedge clk);
        #1 cmp_fault(bus_fault, |(unit_access & ~en));
      end
      rd_chk(OFS_POWER_STATE);
    end
    $display("test modes done");
    // Reset again in mid-run with registers and state set
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    m_run = 32'h0;
    m_slp = 32'h0;
    m_deep = 32'h0;
    m_cfg = 32'h0;
    for (int i = 0; i < 4; i++) rd_chk(regs[i]);
    #1 cmp_en(unit_clk_en, 11'h000);
    cmp_fault(bus_fault, |unit_access);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
